// ===== hdl/far_regs.vh
// register offsets, field positions and op codes for the field address register group
// assumes a 32-bit axi4-lite slave with one aligned word per register
`ifndef FAR_REGS_VH
`define FAR_REGS_VH
`define FAR_OFF_MARKER    8'h00
`define FAR_OFF_INTERP    8'h04
`define FAR_OFF_FADDR     8'h08
`define FAR_OFF_FDESC     8'h0C
`define FAR_OFF_CMP       8'h10
`define FAR_OFF_LIMIT     8'h14
`define FAR_OFF_BASE      8'h18
`define FAR_OFF_CTRL      8'h1C
`define FAR_OFF_PADLO     8'h20
`define FAR_OFF_PADHI     8'h24
`define FAR_OFF_CMD       8'h28
`define FAR_OFF_STAT      8'h2C
`define FAR_OFF_MEMADDR   8'h30
`define FAR_OFF_MEMDATA   8'h34
`define FAR_OFF_UADDR     8'h38
`define FAR_OFF_NIBBLE    8'h40
`define FAR_OP_FA_UP      4'h1
`define FAR_OP_FA_DN      4'h2
`define FAR_OP_FL_UP      4'h3
`define FAR_OP_FL_DN      4'h4
`define FAR_OP_PAD_WR     4'h5
`define FAR_OP_PAD_RD     4'h6
`define FAR_OP_FA_PADUP   4'h7
`define FAR_OP_FA_PADDN   4'h8
`define FAR_OP_PAD_LOAD   4'h9
`define FAR_OP_PAD_STORE  4'hA
`define FAR_OP_PAD_SWAP   4'hB
`define FAR_OP_SUM_ADDR   4'hC
`define FAR_OP_MEM_RD     4'hD
`define FAR_OP_MEM_WR     4'hE
`define FAR_OP_MSG        4'hF
`define FAR_BIT_OVR       2
`define FAR_BIT_RD_OOB    1
`define FAR_BIT_WR_OOB    0
`define FAR_BIT_ADMIN     2
`define FAR_CMP_EQ        3
`define FAR_CMP_GT        2
`define FAR_CMP_LT        1
`define FAR_CMP_NZ        0
`endif

// ===== hdl/far_top.v
// field address register group: marker, interpreter, field address and descriptor,
// scratchpad, length compare and base/limit checking, reached over axi4-lite
// assumes one clock and a memory that answers a read within its one-cycle request
`timescale 1ns/1ns
`default_nettype none
`include "far_regs.vh"
// Summary of operation
// - marker word whole and nibble addressable
// - message moves marker to/from memory zero
// - sum op loads address with marker+interpreter
// - interpreter word whole and nibble addressable
// - message port/channel in low seven interpreter bits
// - memory transfers use operands, marker, interpreter
// - field address steps by literal or count
// - address steps by pad; pad load/store/swap
// - field address wraps silently
// - field address gives diagnostic cache address
// - descriptor split unit, type, length fields
// - length steps; overflow wraps, underflow saturates zero
// - sixteen 48-bit scratchpad words
// - pad write latch then array clock
// - pad read stalls behind pending write
// - read-only length compare flag nibble
// - bounds check sets write or read flags
// - reads always; out-of-bounds writes need override
// - address equal base or limit in bounds
// - only initial field address checked
// - outside administrative memory sets status bit 2
// - counting happens even when cycle suppressed
// - variable count is low five control bits
// - override never blocks flag setting
module far_top #(
	parameter ADMIN_TOP = 24'hFFFFFF // highest administrative bit address
) (
	input  wire        ref_clk,
	input  wire        reset,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	output reg         mem_req,
	output reg         mem_we,
	output reg  [23:0] mem_addr,
	output reg  [23:0] mem_wdata,
	input  wire [23:0] mem_rdata,
	output reg  [23:0] cache_addr,
	output reg  [17:0] uaddr
);
	// registers; program-visible ones are undefined until software writes them, handshake and pending state is reset
	reg [23:0] marker_word_reg;      // marker word
	reg [23:0] interp_word_reg;      // interpreter word
	reg [23:0] field_address_reg;    // absolute bit address
	reg [23:0] field_descriptor_reg; // unit, type, length
	reg [23:0] limit_bound_reg;      // upper bound
	reg [23:0] base_bound_reg;       // lower bound
	reg [7:0]  ctrl_byte;            // arithmetic-control byte
	reg [3:0]  memory_error_nibble;  // bounds flags and override
	reg [3:0]  memory_error_status_reg; // memory error status
	reg [47:0] pad [0:15];           // scratchpad array
	reg [47:0] pad_data;             // staging word for pad writes/reads
	reg [47:0] pad_latch;            // write latch
	reg [3:0]  pad_latch_idx;        // latched write index
	reg        pad_pending;          // array write still due
	reg [3:0]  pend_op;              // op stalled behind a pad write
	reg        pend_valid;           // stalled op waiting
	reg [3:0]  pend_idx;             // stalled op pad index
	reg [1:0]  pend_sel;             // stalled op register select
	reg [1:0]  op_sel;               // memory operand: 0 marker 1 interp
	reg        msg_dir;              // message direction: 1 memory to marker
	reg [23:0] mem_rd_buf;           // last memory read data
	reg        mem_rd_wait;          // read data due next cycle
	reg [2:0]  nib_idx;              // selected nibble, 0 least significant
	reg [1:0]  nib_tgt;              // nibble target: 0 marker 1 interp 2 descriptor
	reg [7:0]  wr_addr;              // captured write address
	reg [31:0] wr_data;              // captured write data
	reg [3:0]  wr_strb;              // captured byte enables
	reg        aw_held;              // write address captured
	reg        w_held;               // write data captured

	// step size from literal or the variable length count
	wire [4:0]  variable_length_count = ctrl_byte[4:0];
	// literal and count select come straight from the command word, so a step
	// always uses the command that executes in this very cycle
	wire [15:0] step = wr_data[11] ? {11'h000, variable_length_count} : wr_data[31:16];
	wire [15:0] field_length_count = field_descriptor_reg[15:0];
	wire [15:0] pad_field_length = pad[0][15:0];

	// bounds test, ends inclusive, initial address only
	wire in_bounds = (field_address_reg >= base_bound_reg) && (field_address_reg <= limit_bound_reg);
	wire out_admin = field_address_reg > ADMIN_TOP;

	// length compare flags
	wire [3:0] length_compare_bits = {field_length_count == pad_field_length,
		field_length_count > pad_field_length, field_length_count < pad_field_length,
		field_length_count != 16'h0000};

	// byte-lane merge of a write into an old value
	function [31:0] far_merge;
		input [31:0] old_v;
		input [31:0] new_v;
		input [3:0]  strb;
		integer k;
		begin
			far_merge = old_v;
			for (k = 0; k < 4; k = k + 1) begin
				if (strb[k])
					far_merge[k*8 +: 8] = new_v[k*8 +: 8];
			end
		end
	endfunction

	// one nibble out of a 24-bit word; indices past the sixth read as zero
	function [3:0] far_nib_get;
		input [23:0] w;
		input [2:0]  n;
		begin
			far_nib_get = 4'h0;
			if (n < 3'h6)
				far_nib_get = w[n*4 +: 4];
		end
	endfunction

	// one nibble replaced in a 24-bit word; indices past the sixth change nothing
	function [23:0] far_nib_put;
		input [23:0] w;
		input [2:0]  n;
		input [3:0]  v;
		begin
			far_nib_put = w;
			if (n < 3'h6)
				far_nib_put[n*4 +: 4] = v;
		end
	endfunction

	// word picked by a nibble target code: 0 marker, 1 interpreter, else descriptor
	function [23:0] far_nib_word;
		input [1:0] t;
		begin
			case (t)
				2'h0:    far_nib_word = marker_word_reg;
				2'h1:    far_nib_word = interp_word_reg;
				default: far_nib_word = field_descriptor_reg;
			endcase
		end
	endfunction

	// readback decode
	function [31:0] far_read;
		input [7:0] a;
		begin
			case (a)
				`FAR_OFF_MARKER:  far_read = {8'h00, marker_word_reg};
				`FAR_OFF_INTERP:  far_read = {8'h00, interp_word_reg};
				`FAR_OFF_FADDR:   far_read = {8'h00, field_address_reg};
				`FAR_OFF_FDESC:   far_read = {8'h00, field_descriptor_reg};
				`FAR_OFF_CMP:     far_read = {28'h0000000, length_compare_bits};
				`FAR_OFF_LIMIT:   far_read = {8'h00, limit_bound_reg};
				`FAR_OFF_BASE:    far_read = {8'h00, base_bound_reg};
				`FAR_OFF_CTRL:    far_read = {20'h00000, memory_error_nibble, ctrl_byte};
				`FAR_OFF_PADLO:   far_read = {8'h00, pad_data[23:0]};
				`FAR_OFF_PADHI:   far_read = {8'h00, pad_data[47:24]};
				`FAR_OFF_STAT:    far_read = {24'h000000, pend_valid | pad_pending, 3'b000, memory_error_status_reg};
				`FAR_OFF_MEMDATA: far_read = {8'h00, mem_rd_buf};
				`FAR_OFF_UADDR:   far_read = {14'h0000, uaddr};
				`FAR_OFF_NIBBLE:  far_read = {22'h0, nib_tgt, 1'b0, nib_idx, far_nib_get(far_nib_word(nib_tgt), nib_idx)};
				default:          far_read = 32'h00000000;
			endcase
		end
	endfunction

	wire        wr_fire = aw_held && w_held && !s_axi_bvalid;
	wire [31:0] wm = far_merge(far_read(wr_addr), wr_data, wr_strb);
	// nibble port write: target word with one nibble replaced
	wire [23:0] nib_new = far_nib_put(far_nib_word(wr_data[9:8]), wr_data[6:4], wr_data[3:0]);
	wire        cmd_go = wr_fire && (wr_addr == `FAR_OFF_CMD);
	wire [3:0]  cmd_op = cmd_go ? wr_data[3:0] : 4'h0;
	// a pad read or exchange waits while an array write is still due
	wire        cmd_pad_rd = (cmd_op == `FAR_OP_PAD_RD) || (cmd_op == `FAR_OP_PAD_LOAD) ||
		(cmd_op == `FAR_OP_PAD_SWAP) || (cmd_op == `FAR_OP_FA_PADUP) || (cmd_op == `FAR_OP_FA_PADDN);
	wire        stall = cmd_go && cmd_pad_rd && pad_pending;
	wire        run_pend = pend_valid && !pad_pending;
	wire [3:0]  op = run_pend ? pend_op : (stall ? 4'h0 : cmd_op);
	wire [3:0]  idx = run_pend ? pend_idx : wr_data[7:4];
	wire [1:0]  sel = run_pend ? pend_sel : wr_data[9:8];
	wire [23:0] mem_src = sel[0] ? interp_word_reg : marker_word_reg;
	wire        is_wr = (op == `FAR_OP_MEM_WR) || ((op == `FAR_OP_MSG) && !wr_data[10]);
	wire        is_mem = (op == `FAR_OP_MEM_RD) || (op == `FAR_OP_MEM_WR);

	// axi4-lite slave channels
	always @(posedge ref_clk) begin
		if (reset) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'b00;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rresp   <= 2'b00;
			s_axi_rdata   <= 32'h00000000;
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			wr_addr       <= 8'h00;
			wr_data       <= 32'h00000000;
			wr_strb       <= 4'h0;
		end else begin
			// take address and data in either order
			s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
			s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				wr_addr <= {s_axi_awaddr[7:2], 2'b00};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held  <= 1'b1;
				wr_data <= s_axi_wdata;
				wr_strb <= s_axi_wstrb;
			end
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			// one-cycle read answer
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= far_read({s_axi_araddr[7:2], 2'b00});
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// control state that needs a defined value
	always @(posedge ref_clk) begin
		if (reset) begin
			pad_pending <= 1'b0;
			pend_valid  <= 1'b0;
			mem_rd_wait <= 1'b0;
			mem_req     <= 1'b0;
			mem_we      <= 1'b0;
		end else begin
			// second pad clock always follows the latch clock
			pad_pending <= (op == `FAR_OP_PAD_WR) || (op == `FAR_OP_PAD_STORE) || (op == `FAR_OP_PAD_SWAP);
			if (stall)
				pend_valid <= 1'b1;
			else if (run_pend)
				pend_valid <= 1'b0;
			mem_req     <= is_mem || (op == `FAR_OP_MSG) ? (!is_wr || in_bounds || memory_error_nibble[`FAR_BIT_OVR] || (op == `FAR_OP_MSG)) : 1'b0;
			mem_we      <= is_wr;
			mem_rd_wait <= (op == `FAR_OP_MEM_RD) || ((op == `FAR_OP_MSG) && wr_data[10]);
		end
	end

	// data path; no reset so contents stay undefined until written
	always @(posedge ref_clk) begin
		if (stall) begin
			pend_op  <= cmd_op;
			pend_idx <= wr_data[7:4];
			pend_sel <= wr_data[9:8];
		end
		// operand and direction stay for the read data that returns a cycle later
		if (cmd_go && !run_pend) begin
			op_sel       <= wr_data[9:8];
			msg_dir      <= wr_data[10];
		end
		// plain register writes, whole words or bytes (nibbles via the nibble port)
		if (wr_fire) begin
			case (wr_addr)
				`FAR_OFF_MARKER:  marker_word_reg <= wm[23:0];
				`FAR_OFF_INTERP:  interp_word_reg <= wm[23:0];
				`FAR_OFF_FADDR:   field_address_reg <= wm[23:0];
				`FAR_OFF_FDESC:   field_descriptor_reg <= wm[23:0];
				`FAR_OFF_LIMIT:   limit_bound_reg <= wm[23:0];
				`FAR_OFF_BASE:    base_bound_reg <= wm[23:0];
				`FAR_OFF_CTRL: begin
					ctrl_byte           <= wm[7:0];
					memory_error_nibble <= wm[11:8];
				end
				`FAR_OFF_PADLO:   pad_data[23:0] <= wm[23:0];
				`FAR_OFF_PADHI:   pad_data[47:24] <= wm[23:0];
				`FAR_OFF_STAT:    memory_error_status_reg <= wm[3:0];
				`FAR_OFF_MEMADDR: field_address_reg <= wm[23:0];
				`FAR_OFF_UADDR:   uaddr <= wm[17:0];
				`FAR_OFF_NIBBLE: begin
					// select a nibble; bit 12 also stores the new value into it
					nib_idx <= wr_data[6:4];
					nib_tgt <= wr_data[9:8];
					if (wr_data[12]) begin
						case (wr_data[9:8])
							2'h0:    marker_word_reg <= nib_new;
							2'h1:    interp_word_reg <= nib_new;
							default: field_descriptor_reg <= nib_new;
						endcase
					end
				end
				default: ;
			endcase
		end
		// counting proceeds whether or not the memory cycle does
		case (op)
			`FAR_OP_FA_UP:    field_address_reg <= field_address_reg + {8'h00, step};
			`FAR_OP_FA_DN:    field_address_reg <= field_address_reg - {8'h00, step};
			`FAR_OP_FL_UP:    field_descriptor_reg[15:0] <= field_length_count + step;
			`FAR_OP_FL_DN:    field_descriptor_reg[15:0] <= (step > field_length_count) ? 16'h0000 :
				field_length_count - step;
			`FAR_OP_FA_PADUP: field_address_reg <= field_address_reg + pad[idx][47:24];
			`FAR_OP_FA_PADDN: field_address_reg <= field_address_reg - pad[idx][47:24];
			`FAR_OP_PAD_RD:   pad_data <= pad[idx];
			`FAR_OP_PAD_LOAD, `FAR_OP_PAD_SWAP: begin
				field_address_reg    <= pad[idx][47:24];
				field_descriptor_reg <= pad[idx][23:0];
			end
			`FAR_OP_SUM_ADDR: uaddr <= marker_word_reg[17:0] + interp_word_reg[17:0];
			default: ;
		endcase
		// first pad clock: latch the word
		if (op == `FAR_OP_PAD_WR) begin
			pad_latch     <= pad_data;
			pad_latch_idx <= idx;
		end else if ((op == `FAR_OP_PAD_STORE) || (op == `FAR_OP_PAD_SWAP)) begin
			pad_latch     <= {field_address_reg, field_descriptor_reg};
			pad_latch_idx <= idx;
		end
		// second pad clock: write the array
		if (pad_pending)
			pad[pad_latch_idx] <= pad_latch;
		// bounds flags set whatever the override says
		if (is_mem && !in_bounds) begin
			if (is_wr)
				memory_error_nibble[`FAR_BIT_WR_OOB] <= 1'b1;
			else
				memory_error_nibble[`FAR_BIT_RD_OOB] <= 1'b1;
		end
		if (is_mem && out_admin)
			memory_error_status_reg[`FAR_BIT_ADMIN] <= 1'b1;
		// memory request payload
		if (op == `FAR_OP_MSG) begin
			mem_addr  <= 24'h000000;
			mem_wdata <= marker_word_reg;
			interp_word_reg[6:0] <= wr_data[22:16];
		end else if (is_mem) begin
			mem_addr  <= field_address_reg;
			mem_wdata <= mem_src;
		end
		cache_addr <= field_address_reg;
		// read data returns to marker or interpreter
		if (mem_rd_wait) begin
			mem_rd_buf <= mem_rdata;
			if (msg_dir || !op_sel[0])
				marker_word_reg <= mem_rdata;
			else
				interp_word_reg <= mem_rdata;
		end
	end
endmodule
`default_nettype wire

// ===== verification/far_checker.sv
// port checker for the field address register group
// assumes it is bound into far_top; one clock, sync reset
`timescale 1ns/1ns
`default_nettype none
module far_checker (
	input wire logic       ref_clk,
	input wire logic       reset,
	input wire logic       s_axi_awready,
	input wire logic       s_axi_wready,
	input wire logic       s_axi_bvalid,
	input wire logic       s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic       s_axi_arready,
	input wire logic       s_axi_rvalid,
	input wire logic       s_axi_rready,
	input wire logic [1:0] s_axi_rresp,
	input wire logic       mem_req
);
	// one domain, so clock and reset are given once
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);
	AST_AW_PULSE: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("awready stood longer than one cycle");
	AST_W_TO_B: assert property (s_axi_wready |-> ##[1:3] s_axi_bvalid)
		else $error("write response late");
	AST_B_ONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("second write response");
	AST_BRESP_OK: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0)
		else $error("write response not okay");
	AST_AR_TO_R: assert property (s_axi_arready |=> s_axi_rvalid)
		else $error("read data not one cycle after arready");
	AST_R_ONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("second read data beat");
	AST_RRESP_OK: assert property (s_axi_rvalid |-> s_axi_rresp == 2'h0)
		else $error("read response not okay");
	AST_MEM_PULSE: assert property (mem_req |=> !mem_req)
		else $error("memory request longer than one cycle");
	AST_QUIET_RESET: assert property ($fell(reset) |-> !mem_req && !s_axi_bvalid && !s_axi_rvalid)
		else $error("activity right after reset");
endmodule
bind far_top far_checker u_chk (
	.ref_clk(ref_clk), .reset(reset), .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.s_axi_rresp(s_axi_rresp), .mem_req(mem_req)
);
`default_nettype wire

// ===== verification/far_mem_model.sv
// behavioural main memory behind the bounds-checked field address
// assumes one-cycle requests; read data stands while the read request does
`timescale 1ns/1ns
`default_nettype none
module far_mem_model (
	input  wire logic        ref_clk,
	input  wire logic        mem_req,
	input  wire logic        mem_we,
	input  wire logic [23:0] mem_addr,
	input  wire logic [23:0] mem_wdata,
	output logic      [23:0] mem_rdata,
	output logic      [7:0]  wr_cnt,
	output logic      [23:0] last_wa,
	output logic      [23:0] last_wd
);
	logic [23:0] cells [256]; // low address byte picks a cell
	logic [23:0] rd_last;     // value the read bus showed last cycle
	// known pattern so out-of-bounds reads are recognisable
	initial begin
		for (int i = 0; i < 256; i++)
			cells[i] = 24'hC30000 | 24'(i);
		wr_cnt = 8'h00;
		rd_last = 24'h000000;
		last_wa = 24'h000000;
		last_wd = 24'h000000;
	end
	// a read shows its cell during the request; otherwise the bus shows the inverse
	assign mem_rdata = (mem_req && !mem_we) ? cells[mem_addr[7:0]] : ~rd_last;
	// writes are logged
	always @(posedge ref_clk) begin
		rd_last <= mem_rdata;
		if (mem_req && mem_we) begin
			cells[mem_addr[7:0]] <= mem_wdata;
			wr_cnt <= wr_cnt + 8'h01;
			last_wa <= mem_addr;
			last_wd <= mem_wdata;
		end
	end
endmodule
`default_nettype wire

// ===== verification/tb.sv
// register-level bench for the field address register group
// assumes far_top over axi4-lite with the memory model behind it
`timescale 1ns/1ns
`default_nettype none
`include "far_regs.vh"
module tb;
	logic        ref_clk = 1'b0;
	logic        reset = 1'b1;
	logic [7:0]  s_axi_awaddr = 8'h00;
	logic        s_axi_awvalid = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_wvalid = 1'b0;
	logic [7:0]  s_axi_araddr = 8'h00;
	logic        s_axi_arvalid = 1'b0;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, mem_req, mem_we;
	wire  [1:0]  s_axi_bresp, s_axi_rresp;
	wire  [31:0] s_axi_rdata;
	wire  [23:0] mem_addr, mem_wdata, mem_rdata, cache_addr, last_wa, last_wd;
	wire  [17:0] uaddr;
	wire  [7:0]  wr_cnt;
	int          n_errors = 0;
	int          cmp_count = 0;
	logic [31:0] rv;
	logic [7:0]  offs [6] = '{`FAR_OFF_MARKER, `FAR_OFF_INTERP, `FAR_OFF_FADDR, `FAR_OFF_FDESC, `FAR_OFF_LIMIT,
		`FAR_OFF_BASE};
	logic [31:0] fls [3] = '{32'h10, 32'h20, 32'h0};
	logic [31:0] cmps [3] = '{32'h9, 32'h5, 32'h2};
	logic [31:0] bctl [6] = '{32'h0, 32'h0, 32'h0, 32'h400, 32'h0, 32'h0};
	logic [31:0] bfa [6] = '{32'h80, 32'h10, 32'h81, 32'h0F, 32'h0F, 32'h100};
	logic [31:0] bcmd [6] = '{32'hE, 32'hE, 32'hE, 32'hE, 32'h10D, 32'h10D};
	logic [31:0] bflag [6] = '{32'h0, 32'h0, 32'h1, 32'h5, 32'h2, 32'h2};
	logic [31:0] bwr [6] = '{32'h1, 32'h2, 32'h2, 32'h3, 32'h3, 32'h3};
	// small administrative top so the status bit can be reached
	far_top #(.ADMIN_TOP(24'h0000FF)) DUT (
		.ref_clk(ref_clk), .reset(reset), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(1'b1), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(1'b1), .mem_req(mem_req),
		.mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
		.cache_addr(cache_addr), .uaddr(uaddr));
	far_mem_model u_mem (.ref_clk(ref_clk), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .wr_cnt(wr_cnt), .last_wa(last_wa), .last_wd(last_wd));
	// 125 MHz clock
	always #4 ref_clk = ~ref_clk;
	// compare one value and log a mismatch
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	// axi write: address and data offered together, each released when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
	endtask
	// axi read: data taken at the edge where rvalid is seen
	task automatic rd(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		rv = s_axi_rdata;
	endtask
	// read a register and compare its 24 data bits
	task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk(n, e, rv & 32'h00FFFFFF);
	endtask
	// counts, verdict and end of run
	task automatic results();
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// watchdog against a hung handshake
	initial begin
		repeat (20000) @(posedge ref_clk);
		n_errors++;
		results();
	end
	// main sequence
	initial begin
		repeat (16) @(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
		foreach (offs[i]) begin
			wr(offs[i], 32'h00A5C3F0 ^ 32'(i));
			rc("register", offs[i], 32'h00A5C3F0 ^ 32'(i));
		end
		wr(`FAR_OFF_MARKER, 32'h00123456);
		wr(`FAR_OFF_MARKER, 32'h0000AB00, 4'h2);
		rc("marker byte", `FAR_OFF_MARKER, 32'h0012AB56);
		rc("unmapped", 8'h3C, 32'h0);
		wr(`FAR_OFF_FADDR, 32'h00FFFFFE);
		wr(`FAR_OFF_CMD, 32'h00050001);
		rc("fa up", `FAR_OFF_FADDR, 32'h00000003);
		wr(`FAR_OFF_CTRL, 32'h0000001F);
		wr(`FAR_OFF_CMD, 32'h00000802);
		rc("fa down", `FAR_OFF_FADDR, 32'h00FFFFE4);
		chk("cache addr", 32'h00FFFFE4, {8'h00, cache_addr});
		wr(`FAR_OFF_FDESC, 32'h00000030);
		wr(`FAR_OFF_CMD, 32'h00000804);
		rc("fl count", `FAR_OFF_FDESC, 32'h00000011);
		wr(`FAR_OFF_FDESC, 32'h005A0003);
		wr(`FAR_OFF_CMD, 32'h000A0004);
		rc("fl floor", `FAR_OFF_FDESC, 32'h005A0000);
		wr(`FAR_OFF_FDESC, 32'h0012FFFF);
		wr(`FAR_OFF_CMD, 32'h00010003);
		rc("fl wrap", `FAR_OFF_FDESC, 32'h00120000);
		wr(`FAR_OFF_PADLO, 32'h00222222);
		wr(`FAR_OFF_PADHI, 32'h00111111);
		wr(`FAR_OFF_CMD, 32'h000000F5);
		wr(`FAR_OFF_PADLO, 32'h0);
		wr(`FAR_OFF_PADHI, 32'h0);
		wr(`FAR_OFF_CMD, 32'h000000F6);
		rc("pad lo", `FAR_OFF_PADLO, 32'h00222222);
		rc("pad hi", `FAR_OFF_PADHI, 32'h00111111);
		wr(`FAR_OFF_FADDR, 32'h00000010);
		wr(`FAR_OFF_CMD, 32'h000000F7);
		rc("fa pad", `FAR_OFF_FADDR, 32'h00111121);
		wr(`FAR_OFF_CMD, 32'h0000002A);
		wr(`FAR_OFF_FADDR, 32'h0);
		wr(`FAR_OFF_CMD, 32'h00000029);
		rc("pad load", `FAR_OFF_FADDR, 32'h00111121);
		wr(`FAR_OFF_PADLO, 32'h00000010);
		wr(`FAR_OFF_PADHI, 32'h00000010);
		wr(`FAR_OFF_CMD, 32'h00000005);
		foreach (fls[i]) begin
			wr(`FAR_OFF_FDESC, fls[i]);
			rc("length flags", `FAR_OFF_CMP, cmps[i]);
		end
		wr(`FAR_OFF_CMP, 32'h0000000F);
		rc("flags read only", `FAR_OFF_CMP, 32'h2);
		wr(`FAR_OFF_BASE, 32'h10);
		wr(`FAR_OFF_LIMIT, 32'h80);
		wr(`FAR_OFF_MARKER, 32'h00ABCDEF);
		foreach (bfa[i]) begin
			wr(`FAR_OFF_CTRL, bctl[i]);
			wr(`FAR_OFF_FADDR, bfa[i]);
			wr(`FAR_OFF_CMD, bcmd[i]);
			rd(`FAR_OFF_CTRL);
			chk("bound flags", bflag[i], {28'h0, rv[11:8]});
			chk("write count", bwr[i], {24'h0, wr_cnt});
		end
		chk("write data", 32'h00ABCDEF, {8'h00, last_wd});
		rc("read data", `FAR_OFF_INTERP, 32'h00C30000);
		rd(`FAR_OFF_STAT);
		chk("admin bit", 32'h1, {31'h0, rv[`FAR_BIT_ADMIN]});
		wr(`FAR_OFF_BASE, 32'h0);
		wr(`FAR_OFF_LIMIT, 32'h00FFFFFF);
		wr(`FAR_OFF_MARKER, 32'h0013579B);
		wr(`FAR_OFF_CMD, 32'h0055000F);
		rd(`FAR_OFF_INTERP);
		chk("port info", 32'h55, {25'h0, rv[6:0]});
		chk("msg addr", 32'h0, {8'h00, last_wa});
		chk("msg data", 32'h0013579B, {8'h00, last_wd});
		wr(`FAR_OFF_MARKER, 32'h0);
		wr(`FAR_OFF_CMD, 32'h0055040F);
		rc("msg in", `FAR_OFF_MARKER, 32'h0013579B);
		wr(`FAR_OFF_MARKER, 32'h00FFFFFF);
		wr(`FAR_OFF_INTERP, 32'h00000002);
		wr(`FAR_OFF_CMD, 32'h0000000C);
		rc("uaddr reg", `FAR_OFF_UADDR, 32'h1);
		chk("uaddr pin", 32'h1, {14'h0, uaddr});
		wr(`FAR_OFF_NIBBLE, 32'h00001025);
		rc("marker nibble", `FAR_OFF_MARKER, 32'h00FFF5FF);
		wr(`FAR_OFF_NIBBLE, 32'h00000100);
		rc("interp nibble", `FAR_OFF_NIBBLE, 32'h00000102);
		wr(`FAR_OFF_NIBBLE, 32'h0000125A);
		rc("unit nibble", `FAR_OFF_FDESC, 32'h00A00000);
		rc("nibble select", `FAR_OFF_NIBBLE, 32'h0000025A);
		results();
	end
endmodule
`default_nettype wire
